//--- design/timer_pair_pkg.sv
// constants shared by the dual 8-bit timer / event counter
package timer_pair_pkg;
   // word indices on the register bus (byte address is four times these)
   localparam logic [31:0] CS0_IDX  = 32'hfffff5c4;
   localparam logic [31:0] CS1_IDX  = 32'hfffff5c5;
   localparam logic [31:0] MC0_IDX  = 32'hfffff5c6;
   localparam logic [31:0] MC1_IDX  = 32'hfffff5c7;
   localparam logic [31:0] CMP0_IDX = 32'hfffff5c8;
   localparam logic [31:0] CMP1_IDX = 32'hfffff5c9;
   localparam logic [31:0] CNT0_IDX = 32'hfffff5ca;
   localparam logic [31:0] CNT1_IDX = 32'hfffff5cb;
   // mode control bit positions
   localparam int RUN_BIT  = 7;
   localparam int PWM_BIT  = 6;
   localparam int CASC_BIT = 4;
   localparam int SET_BIT  = 3;
   localparam int CLR_BIT  = 2;
   localparam int INV_BIT  = 1;
   localparam int OE_BIT   = 0;
   // stored bits: run, pwm, cascade (kept by channel 1 only), invert, enable (preset pair never stored)
   localparam logic [7:0] MC_STORE_MASK = 8'hd3;
   localparam logic [7:0] MC_RESET      = 8'h00;
   localparam logic [2:0] CS_RESET      = 3'h0;
   localparam logic [7:0] CMP_RESET     = 8'h00;
   localparam logic [7:0] CNT_RESET     = 8'h00;
   // clock select codes
   localparam logic [2:0] SEL_FALL  = 3'h0;
   localparam logic [2:0] SEL_RISE  = 3'h1;
   localparam logic [2:0] SEL_DIV1  = 3'h2;
   localparam logic [2:0] SEL_DIV2  = 3'h3;
   localparam logic [2:0] SEL_DIV4  = 3'h4;
   localparam logic [2:0] SEL_DIV64 = 3'h5;
   localparam logic [2:0] SEL_DIV256 = 3'h6;
   localparam logic [2:0] SEL_OTHER = 3'h7;
   typedef enum logic {BUS_IDLE, BUS_DONE} bus_state_t;
endpackage

//--- design/timer_pair.sv
// dual 8-bit timer / event counter with avalon-mm register slave
//
// Register access over Avalon-MM was decided locally.
module timer_pair
   import timer_pair_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [31:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic [1:0]  event_input_i,
   input  wire logic        other_timer_match_irq_i,
   output logic      [1:0]  timer_output_o,
   output logic      [1:0]  match_interrupt_o
);

   bus_state_t  bus_q;
   logic [31:0] rdata_q;
   logic [2:0]  cs_q       [2];
   logic [7:0]  mc_q       [2];
   logic [7:0]  cmp_q      [2];
   logic [7:0]  pwm_cmp_q  [2];
   logic [7:0]  cnt_q      [2];
   logic [1:0]  ff_q;
   logic [1:0]  irq_q;
   logic [7:0]  presc_q;
   logic [1:0]  sync1_q, sync2_q, sync3_q, lvl_q;
   logic [1:0]  rise, fall, tick, run, pwm, wr_mc, preset_set, preset_clr;
   logic        req, wr_fire, cascade;
   logic [15:0] cnt16, cmp16;
   logic [7:0]  wbyte;

   // one clock-select decode for both channels
   function automatic logic sel_tick(input logic [2:0] sel, input logic [7:0] p,
                                     input logic f, input logic r, input logic o);
      logic t;
      t = 1'b0;
      case (sel)
         SEL_FALL:   t = f;
         SEL_RISE:   t = r;
         SEL_DIV1:   t = 1'b1;
         SEL_DIV2:   t = p[0];
         SEL_DIV4:   t = &p[1:0];
         SEL_DIV64:  t = &p[5:0];
         SEL_DIV256: t = &p;
         default:    t = o;
      endcase
      return t;
   endfunction

   // register read mux shared by the bus logic
   function automatic logic [7:0] reg_read(input logic [31:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == CS0_IDX) begin
         v = {5'h00, cs_q[0]};
      end else if (a == CS1_IDX) begin
         v = {5'h00, cs_q[1]};
      end else if (a == MC0_IDX) begin
         v = mc_q[0];
      end else if (a == MC1_IDX) begin
         v = mc_q[1];
      end else if (a == CMP0_IDX) begin
         v = cmp_q[0];
      end else if (a == CMP1_IDX) begin
         v = cmp_q[1];
      end else if (a == CNT0_IDX) begin
         v = cnt_q[0];
      end else if (a == CNT1_IDX) begin
         v = cnt_q[1];
      end
      return v;
   endfunction

   // bus handshake: every access waits exactly one cycle
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & (bus_q != BUS_DONE);
   assign wr_fire           = avs_write_i & (bus_q == BUS_DONE) & avs_byteenable_i[0];
   assign wbyte             = avs_writedata_i[7:0];
   assign avs_readdata_o    = rdata_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_q <= BUS_IDLE;
      end else begin
         case (bus_q)
            BUS_IDLE: if (req) bus_q <= BUS_DONE;
            default:  bus_q <= BUS_IDLE;
         endcase
      end
   end

   // read data latched in the first cycle, stands through the answer edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read_i && bus_q == BUS_IDLE) begin
         rdata_q <= {24'h00_0000, reg_read(avs_address_i)};
      end
   end

   // clock select: only three bits exist, upper bits read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_q[0] <= CS_RESET;
         cs_q[1] <= CS_RESET;
      end else if (wr_fire) begin
         if (avs_address_i == CS0_IDX) cs_q[0] <= wbyte[2:0];
         if (avs_address_i == CS1_IDX) cs_q[1] <= wbyte[2:0];
      end
   end

   assign wr_mc[0] = wr_fire & (avs_address_i == MC0_IDX);
   assign wr_mc[1] = wr_fire & (avs_address_i == MC1_IDX);

   // mode control: preset pair is never stored, so it reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mc_q[0] <= MC_RESET;
         mc_q[1] <= MC_RESET;
      end else begin
         if (wr_mc[0]) mc_q[0] <= wbyte & MC_STORE_MASK & ~(8'h01 << CASC_BIT);
         if (wr_mc[1]) mc_q[1] <= wbyte & MC_STORE_MASK;
      end
   end

   // compare registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_q[0] <= CMP_RESET;
         cmp_q[1] <= CMP_RESET;
      end else if (wr_fire) begin
         if (avs_address_i == CMP0_IDX) cmp_q[0] <= wbyte;
         if (avs_address_i == CMP1_IDX) cmp_q[1] <= wbyte;
      end
   end

   // preset pulses act only on the write itself; 11 is ignored
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         preset_set[i] = wr_mc[i] & wbyte[SET_BIT] & ~wbyte[CLR_BIT] & ~wbyte[PWM_BIT];
         preset_clr[i] = wr_mc[i] & ~wbyte[SET_BIT] & wbyte[CLR_BIT] & ~wbyte[PWM_BIT];
      end
   end

   // free-running prescaler, slower rates are enable pulses from it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_q <= 8'h00;
      end else begin
         presc_q <= presc_q + 8'h01;
      end
   end

   // event pins: three flops, a change counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 2'b00;
         sync2_q <= 2'b00;
         sync3_q <= 2'b00;
         lvl_q   <= 2'b00;
      end else begin
         sync1_q <= event_input_i;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < 2; i++) begin
            if (sync2_q[i] == sync3_q[i]) lvl_q[i] <= sync3_q[i];
         end
      end
   end

   assign rise    = sync2_q & sync3_q & ~lvl_q;
   assign fall    = ~sync2_q & ~sync3_q & lvl_q;
   assign cascade = mc_q[1][CASC_BIT];

   // count clock ticks; upper counter borrows the lower selection in cascade
   always_comb begin
      tick[0] = sel_tick(cs_q[0], presc_q, fall[0], rise[0], other_timer_match_irq_i);
      tick[1] = cascade ? tick[0]
                        : sel_tick(cs_q[1], presc_q, fall[1], rise[1], other_timer_match_irq_i);
      for (int i = 0; i < 2; i++) begin
         pwm[i] = mc_q[i][PWM_BIT] & ~(cascade);
         run[i] = mc_q[i][RUN_BIT];
      end
   end

   assign cnt16 = {cnt_q[1], cnt_q[0]};
   assign cmp16 = {cmp_q[1], cmp_q[0]};

   // counters and match pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q[0]     <= CNT_RESET;
         cnt_q[1]     <= CNT_RESET;
         pwm_cmp_q[0] <= CMP_RESET;
         pwm_cmp_q[1] <= CMP_RESET;
         irq_q        <= 2'b00;
      end else begin
         irq_q <= 2'b00;
         if (cascade) begin
            // either run bit low holds the 16-bit pair at zero
            if (!run[0] || !run[1]) begin
               cnt_q[0] <= CNT_RESET;
               cnt_q[1] <= CNT_RESET;
            end else if (tick[0]) begin
               if (cnt16 == cmp16) begin
                  cnt_q[0] <= CNT_RESET;
                  cnt_q[1] <= CNT_RESET;
                  irq_q[0] <= 1'b1;
               end else begin
                  {cnt_q[1], cnt_q[0]} <= cnt16 + 16'h0001;
               end
            end
         end else begin
            for (int i = 0; i < 2; i++) begin
               if (!run[i]) begin
                  cnt_q[i]     <= CNT_RESET;
                  pwm_cmp_q[i] <= cmp_q[i];
               end else if (tick[i]) begin
                  if (pwm[i]) begin
                     cnt_q[i] <= cnt_q[i] + 8'h01;
                     // new compare takes effect only at overflow
                     if (cnt_q[i] == 8'hff) begin
                        pwm_cmp_q[i] <= cmp_q[i];
                     end
                     if (cnt_q[i] + 8'h01 == pwm_cmp_q[i] && cnt_q[i] != 8'hff) begin
                        irq_q[i] <= 1'b1;
                     end
                  end else if (cnt_q[i] == cmp_q[i]) begin
                     cnt_q[i] <= CNT_RESET;
                     irq_q[i] <= 1'b1;
                  end else begin
                     cnt_q[i] <= cnt_q[i] + 8'h01;
                  end
               end
            end
         end
      end
   end

   assign match_interrupt_o = irq_q;

   // output flip-flops: presets, inversion on match, pwm active window
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ff_q <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (pwm[i] && !run[i]) begin
               ff_q[i] <= 1'b0;
            end else if (preset_set[i]) begin
               ff_q[i] <= 1'b1;
            end else if (preset_clr[i]) begin
               ff_q[i] <= 1'b0;
            end else if (pwm[i] && tick[i]) begin
               if (cnt_q[i] == 8'hff) begin
                  ff_q[i] <= (cmp_q[i] != 8'h00);
               end else if (cnt_q[i] + 8'h01 == pwm_cmp_q[i]) begin
                  ff_q[i] <= 1'b0;
               end
            end else if (!pwm[i] && mc_q[i][INV_BIT] && irq_q[i]) begin
               ff_q[i] <= ~ff_q[i];
            end
         end
      end
   end

   // pin drives straight from stored bits so mode changes show at once
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         timer_output_o[i] = mc_q[i][OE_BIT] &
                             (pwm[i] ? (ff_q[i] ^ mc_q[i][INV_BIT]) : ff_q[i]);
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_stop_clears_cnt: assert property (
      !cascade && !run[0] |=> cnt_q[0] == 8'h00)
      else $error("counter not cleared while stopped");
   a_match_restart: assert property (
      !cascade && run[0] && !pwm[0] && tick[0] && cnt_q[0] == cmp_q[0]
      |=> cnt_q[0] == 8'h00 && match_interrupt_o[0])
      else $error("clear-on-match did not restart");
   a_count_step: assert property (
      !cascade && run[0] && !pwm[0] && !tick[0] |=> $stable(cnt_q[0]))
      else $error("counter moved without a tick");
   a_preset_reads_zero: assert property (
      mc_q[0][3:2] == 2'b00 && mc_q[1][3:2] == 2'b00)
      else $error("preset bits stored");
   a_oe_forces_low: assert property (
      !mc_q[1][OE_BIT] |-> timer_output_o[1] == 1'b0)
      else $error("output not low when disabled");
   a_pwm_stop_idle: assert property (
      pwm[0] && !run[0] && mc_q[0][OE_BIT] |=> ##1 !pwm[0] || run[0]
      || !mc_q[0][OE_BIT] || timer_output_o[0] == mc_q[0][INV_BIT])
      else $error("pwm output not inactive when stopped");
   a_cascade_irq_low: assert property (
      cascade |=> !match_interrupt_o[1])
      else $error("upper interrupt in cascade");
   a_lower_bit4_zero: assert property (
      !mc_q[0][CASC_BIT])
      else $error("lower cascade bit set");
   a_preset_set_ff: assert property (
      preset_set[1] && !(pwm[1] && !run[1]) |=> ff_q[1])
      else $error("preset set ignored");
   a_bus_one_wait: assert property (
      req && bus_q == BUS_IDLE |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not after one wait");

   // read data latched at the first edge must already show the zero upper bits
   a_cs_read_zero: assert property (
      avs_read_i && bus_q == BUS_IDLE
      && (avs_address_i == CS0_IDX || avs_address_i == CS1_IDX)
      |=> avs_readdata_o[7:3] == 5'h00)
      else $error("clock select upper bits not zero");
   a_stop_clears_hi: assert property (
      !cascade && !run[1] |=> cnt_q[1] == 8'h00)
      else $error("upper counter not cleared while stopped");
   // a synchronised pin change gives one tick, never two
   a_edge_once: assert property (
      rise[0] || fall[0] |=> !rise[0] && !fall[0])
      else $error("event edge seen twice");
   // a match pulse only ever follows a count clock tick
   a_irq_needs_tick: assert property (
      !tick[0] |=> !match_interrupt_o[0])
      else $error("match without a count tick");
   a_invert_toggle: assert property (
      !pwm[0] && mc_q[0][INV_BIT] && match_interrupt_o[0]
      && !preset_set[0] && !preset_clr[0]
      |=> ff_q[0] != $past(ff_q[0]))
      else $error("output flip-flop did not invert on match");
   // pwm window: overflow opens it, the reloaded compare closes it
   a_pwm_overflow_on: assert property (
      pwm[0] && run[0] && tick[0] && cnt_q[0] == 8'hff
      && cmp_q[0] != 8'h00 && !preset_clr[0]
      |=> ff_q[0])
      else $error("pwm overflow did not start the active level");
   a_pwm_match_off: assert property (
      pwm[0] && run[0] && tick[0] && cnt_q[0] != 8'hff && !preset_set[0]
      && cnt_q[0] + 8'h01 == pwm_cmp_q[0]
      |=> !ff_q[0] && match_interrupt_o[0])
      else $error("pwm match did not end the active level");
   // in cascade the upper half moves on the lower selection alone
   a_cascade_count: assert property (
      cascade && run[0] && run[1] && tick[0] && cnt16 != cmp16
      |=> cnt16 == $past(cnt16) + 16'h0001)
      else $error("cascade count did not step by one");
   a_cascade_match: assert property (
      cascade && run[0] && run[1] && tick[0] && cnt16 == cmp16
      |=> cnt16 == 16'h0000 && match_interrupt_o[0])
      else $error("cascade match did not restart");
   a_preset_clr_ff: assert property (
      preset_clr[0] && !(pwm[0] && !run[0]) |=> !ff_q[0])
      else $error("preset clear ignored");

   c_match_irq: cover property (match_interrupt_o[0] ##[1:300] match_interrupt_o[0]);
   c_pwm_window: cover property (pwm[0] && run[0] && ff_q[0] ##[1:300] !ff_q[0]);
   c_cascade_irq: cover property (cascade && match_interrupt_o[0]);
   c_event_count: cover property (cs_q[0] == SEL_RISE && rise[0] && run[0]);
   c_square_wave: cover property (!pwm[0] && mc_q[0][INV_BIT] && match_interrupt_o[0]);

endmodule

//--- testbench/event_source.sv
// partner model: external event pins and the neighbouring timer's match line
module event_source (
   input  wire logic       clk_i,
   output logic      [1:0] ev_o,
   output logic            irq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // pins idle low so no edge is seen after reset
   initial begin
      ev_o  = 2'h0;
      irq_o = 1'b0;
   end

   // pins held four cycles each way so the synchroniser never drops an edge
   task automatic burst(input int ch, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         if (ch == 2) begin
            irq_o <= 1'b1;
            @(posedge clk_i);
            irq_o <= 1'b0;
            @(posedge clk_i);
         end else begin
            ev_o[ch] <= 1'b1;
            repeat (4) @(posedge clk_i);
            ev_o[ch] <= 1'b0;
            repeat (4) @(posedge clk_i);
         end
      end
   endtask
endmodule

//--- testbench/timer_pair_tb.sv
// self-checking bench for the dual timer / event counter
module timer_pair_tb;
   import timer_pair_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i, rst_i, read, write, wreq, oirq, prev;
   logic [31:0] address, wdata, rdata, rq;
   logic [3:0]  be;
   logic [1:0]  ev, tout, irq;
   int          n_errors = 0, cmp_count = 0, n_irq0 = 0, n_irq1 = 0, n_high = 0, n_tog = 0;
   int          h, s;
   // cs code, compare, window cycles, expected matches
   int tab[8][4] = '{'{2,1,8,4}, '{3,1,16,4}, '{4,1,32,4}, '{5,1,512,4},
                     '{6,1,2048,4}, '{4,0,32,8}, '{2,255,512,2}, '{2,2,30,10}};

   timer_pair i_timer_pair (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(address),
      .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .event_input_i(ev), .other_timer_match_irq_i(oirq), .timer_output_o(tout),
      .match_interrupt_o(irq));
   event_source i_event_source (.clk_i(clk_i), .ev_o(ev), .irq_o(oirq));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // running tallies; tests compare differences over a window
   always @(posedge clk_i) begin
      n_irq0 <= n_irq0 + int'(irq[0]);
      n_irq1 <= n_irq1 + int'(irq[1]);
      n_high <= n_high + int'(tout[0]);
      n_tog  <= n_tog + int'(tout[0] != prev);
      prev   <= tout[0];
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one bus access; held until waitrequest is sampled low at a rising edge
   task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d);
      @(posedge clk_i);
      address <= a;
      wdata   <= {24'h0, d};
      write   <= w;
      read    <= ~w;
      do @(posedge clk_i); while (wreq !== 1'b0);
      // read data stands at the answer edge; release only after it
      rq = rdata;
      write <= 1'b0;
      read  <= 1'b0;
   endtask

   task automatic rc(input logic [31:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(rq, {24'h0, e});
   endtask

   // mode write, then the pin once settled
   task automatic po(input logic [7:0] d, input logic e);
      acc(1'b1, MC0_IDX, d);
      repeat (2) @(negedge clk_i);
      chk({31'h0, tout[0]}, {31'h0, e});
   endtask

   task automatic win(input int cyc, input int e0, input int e1);
      int s0, s1;
      s0 = n_irq0;
      s1 = n_irq1;
      repeat (cyc) @(posedge clk_i);
      chk(n_irq0 - s0, e0);
      chk(n_irq1 - s1, e1);
   endtask

   // wait for a channel 0 match so a window starts in phase with the period
   task automatic sync0;
      do @(posedge clk_i); while (irq[0] !== 1'b1);
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // the whole run needs well under this span
   initial begin
      #300000;
      n_errors++;
      stop_test();
   end

   initial begin
      rst_i = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = '0;
      wdata = '0;
      be = 4'h1;
      prev = 1'b0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 4; k++) rc(CS0_IDX + k, 8'h00);
      acc(1'b1, 32'h10, 8'h5a);
      rc(32'h10, 8'h00);
      acc(1'b1, CS1_IDX, 8'hff);
      rc(CS1_IDX, 8'h07);
      be <= 4'h0;
      acc(1'b1, CMP0_IDX, 8'h55);
      be <= 4'h1;
      rc(CMP0_IDX, 8'h00);
      acc(1'b1, MC0_IDX, 8'hdf);
      rc(MC0_IDX, 8'hc3);
      acc(1'b1, MC1_IDX, 8'h1c);
      rc(MC1_IDX, 8'h10);
      acc(1'b1, MC1_IDX, 8'h00);
      acc(1'b1, CS1_IDX, 8'h00);
      // interval timing: counter stopped before each clock change
      for (int k = 0; k < 8; k++) begin
         acc(1'b1, MC0_IDX, 8'h00);
         acc(1'b1, CS0_IDX, 8'(tab[k][0]));
         acc(1'b1, CMP0_IDX, 8'(tab[k][1]));
         acc(1'b1, MC0_IDX, 8'h80);
         sync0();
         win(tab[k][2], tab[k][3], 0);
      end
      // event edges and the neighbouring match line, both channels
      for (int c = 0; c < 2; c++) begin
         acc(1'b1, MC0_IDX + c, 8'h00);
         acc(1'b1, CMP0_IDX + c, 8'h01);
         for (int k = 0; k < 3; k++) begin
            acc(1'b1, MC0_IDX + c, 8'h00);
            acc(1'b1, CS0_IDX + c, 8'((k == 2) ? SEL_OTHER : 3'(k)));
            acc(1'b1, MC0_IDX + c, 8'h80);
            fork
               i_event_source.burst((k == 2) ? 2 : c, 6);
               win(70, 3 * (1 - c), 3 * c);
            join
         end
         acc(1'b1, MC0_IDX + c, 8'h00);
      end
      po(8'h01, 1'b0);
      po(8'h09, 1'b1);
      po(8'h0d, 1'b1);
      po(8'h05, 1'b0);
      po(8'h09, 1'b1);
      po(8'h00, 1'b0);
      po(8'h01, 1'b1);
      rc(MC0_IDX, 8'h01);
      // square wave: pin flips on every match only with inversion on
      acc(1'b1, CS0_IDX, 8'(SEL_DIV1));
      acc(1'b1, CMP0_IDX, 8'h01);
      for (int i = 0; i < 2; i++) begin
         acc(1'b1, MC0_IDX, 8'(8'h81 | (i << 1)));
         sync0();
         s = n_tog;
         repeat (16) @(posedge clk_i);
         chk(n_tog - s, 8 * i);
         acc(1'b1, MC0_IDX, 8'h00);
      end
      // pwm: 64 active of 256 cycles, one match per period
      acc(1'b1, CMP0_IDX, 8'h40);
      po(8'h41, 1'b0);
      acc(1'b1, MC0_IDX, 8'hc1);
      repeat (300) @(posedge clk_i);
      h = n_high;
      win(512, 2, 0);
      chk(n_high - h, 128);
      po(8'h41, 1'b0);
      po(8'h43, 1'b1);
      po(8'h00, 1'b0);
      // cascade: 0x0103 gives 260 cycles; upper clock select must not matter
      acc(1'b1, CS1_IDX, 8'(SEL_DIV256));
      acc(1'b1, CMP0_IDX, 8'h03);
      acc(1'b1, CMP1_IDX, 8'h01);
      acc(1'b1, MC1_IDX, 8'h10);
      acc(1'b1, MC1_IDX, 8'h90);
      acc(1'b1, MC0_IDX, 8'h80);
      sync0();
      win(1040, 4, 0);
      acc(1'b1, MC0_IDX, 8'h00);
      acc(1'b1, MC1_IDX, 8'h00);
      // upper channel pin: preset set with output on, then output off
      acc(1'b1, MC1_IDX, 8'h09);
      repeat (2) @(negedge clk_i);
      chk({31'h0, tout[1]}, 32'h1);
      acc(1'b1, MC1_IDX, 8'h00);
      repeat (2) @(negedge clk_i);
      chk({31'h0, tout[1]}, 32'h0);
      stop_test();
   end
endmodule
